// ==== design/gpio_port_defs.svh ====
/*
  Register offsets, field layouts, reset values for the port block.
  Assumes inclusion by bare name from design files.
*/
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define ADDR_W          8
`define PORT_W          8
`define NUM_PORTS       4
`define OFS_MASK_GROUP0 8'h6b
`define OFS_MASK_GROUP1 8'h6c
`define OFS_MASK_GROUP2 8'h6d
`define OFS_MASK_GROUP3 8'h73
`define OFS_GROUP_CTRL  8'h68
`define OFS_MCU_CTRL    8'h55
`define BIT_PULLUP_DIS  4
`define OFS_PORT_BASE   8'h20
`define PORT_STRIDE     8'h03
`define OFS_PINS_SUB    8'h00
`define OFS_DIR_SUB     8'h01
`define OFS_DATA_SUB    8'h02
`define RST_MASK        8'h00
`define RST_CTRL        8'h00

`endif

// ==== design/gpio_port_pkg.sv ====
/*
  Types shared by the port block.
  Assumes nothing beyond the defs header.
*/
package gpio_port_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    SUB_PINS,
    SUB_DIR,
    SUB_DATA,
    SUB_NONE
  } port_sub_t;
endpackage : gpio_port_pkg

// ==== design/pin_sample_if.sv ====
/*
  Carries synchronised pin levels and change pulses between modules.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface pin_sample_if #(parameter int W = 32);
  logic [W-1:0] level;
  logic [W-1:0] changed;
  modport producer (output level, output changed);
  modport consumer (input level, input changed);
endinterface : pin_sample_if

// ==== design/pin_sync.sv ====
/*
  Three-stage input synchroniser with change detection.
  Assumes pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  pin_sample_if.producer    smp
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;

  // Only stage2/stage3 agreement is trusted; stage1 feeds stage2 alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

  assign smp.level   = level;
  // Pulse only once stage2 and stage3 agree on a level new to us
  assign smp.changed = (level ^ stage3) & ~(stage2 ^ stage3);
endmodule : pin_sync

// ==== design/gpio_port_pin_change_mask.sv ====
/*
  Four 8-bit general I/O ports plus pin-change mask registers.
  Assumes a single-cycle I/O register port (address, write strobe with
  data, read strobe) and external pin-change flag logic.
*/
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
module gpio_port_pin_change_mask
  import gpio_port_pkg::*;
#(
  parameter int NP = `NUM_PORTS,
  parameter int PW = `PORT_W
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [`ADDR_W-1:0]   regAddr,
  input  wire logic                 regWrite,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdata,
  input  wire logic [NP*PW-1:0]     altEnable,
  input  wire logic [NP*PW-1:0]     altOut,
  input  wire logic [NP*PW-1:0]     altOe,
  input  wire logic [NP*PW-1:0]     pinIn,
  output logic      [NP*PW-1:0]     pinOut,
  output logic      [NP*PW-1:0]     pinOe,
  output logic      [NP*PW-1:0]     pullupEn,
  output logic      [NP-1:0]        groupChange
);
  localparam int N = NP * PW;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  byte_t      maskReg [NP];
  byte_t      portOutputData [NP];
  byte_t      portDirection [NP];
  logic [7:0] changeGroupControl;
  logic [7:0] mcuControlReg;
  logic       globalPullupDisable;
  logic [N-1:0] maskVec;
  logic [N-1:0] dataVec;
  logic [N-1:0] dirVec;
  logic [NP-1:0] groupEn;

  pin_sample_if #(.W(N)) smp ();

  pin_sync #(.W(N)) u_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pinIn (pinIn),
    .smp   (smp)
  );

  assign globalPullupDisable = mcuControlReg[`BIT_PULLUP_DIS];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [`ADDR_W-1:0] maskOfs(input int g);
    unique case (g)
      0: maskOfs = `OFS_MASK_GROUP0;
      1: maskOfs = `OFS_MASK_GROUP1;
      2: maskOfs = `OFS_MASK_GROUP2;
      default: maskOfs = `OFS_MASK_GROUP3;
    endcase
  endfunction : maskOfs

  function automatic logic [`ADDR_W-1:0] portOfs(input int p,
                                                 input logic [7:0] sub);
    portOfs = `ADDR_W'(`OFS_PORT_BASE + p * `PORT_STRIDE + sub);
  endfunction : portOfs

  // Mask registers write-through; reset keeps every pin disabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int g = 0; g < NP; g++) begin
        maskReg[g] <= `RST_MASK;
      end
    end else if (regWrite) begin
      for (int g = 0; g < NP; g++) begin
        if (regAddr == maskOfs(g)) begin
          maskReg[g] <= regWdata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      changeGroupControl <= `RST_CTRL;
      mcuControlReg      <= `RST_CTRL;
    end else if (regWrite) begin
      if (regAddr == `OFS_GROUP_CTRL) begin
        changeGroupControl <= {4'h0, regWdata[3:0]};
      end
      if (regAddr == `OFS_MCU_CTRL) begin
        mcuControlReg <= regWdata;
      end
    end
  end

  // Byte-wide writes carry the read-modify-write of bit set/clear
  // instructions, so one pin changes while the rest keep their value.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < NP; p++) begin
        portOutputData[p] <= 8'h00;
        portDirection[p]  <= 8'h00;
      end
    end else if (regWrite) begin
      for (int p = 0; p < NP; p++) begin
        if (regAddr == portOfs(p, `OFS_DATA_SUB)) begin
          portOutputData[p] <= regWdata;
        end else if (regAddr == portOfs(p, `OFS_PINS_SUB)) begin
          portOutputData[p] <= portOutputData[p] ^ regWdata;
        end
        if (regAddr == portOfs(p, `OFS_DIR_SUB)) begin
          portDirection[p] <= regWdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= 8'h00;
      for (int g = 0; g < NP; g++) begin
        if (regAddr == maskOfs(g)) begin
          regRdata <= maskReg[g];
        end
      end
      // Three addresses per port; pins reads synchronised levels, and a pins write toggles data
      for (int p = 0; p < NP; p++) begin
        if (regAddr == portOfs(p, `OFS_PINS_SUB)) begin
          regRdata <= smp.level[p*PW +: PW];
        end
        if (regAddr == portOfs(p, `OFS_DIR_SUB)) begin
          regRdata <= portDirection[p];
        end
        if (regAddr == portOfs(p, `OFS_DATA_SUB)) begin
          regRdata <= portOutputData[p];
        end
      end
      if (regAddr == `OFS_GROUP_CTRL) begin
        regRdata <= changeGroupControl;
      end
      if (regAddr == `OFS_MCU_CTRL) begin
        regRdata <= mcuControlReg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers, per pin
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      assign dataVec[gi] = portOutputData[gi / PW][gi % PW];
      assign dirVec[gi]  = portDirection[gi / PW][gi % PW];
      assign maskVec[gi] = maskReg[gi / PW][gi % PW];
      // Alternate override is per pin, so neighbours stay plain I/O
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pinOe[gi]    <= 1'b0;
          pinOut[gi]   <= 1'b0;
          pullupEn[gi] <= 1'b0;
        end else if (altEnable[gi]) begin
          pinOe[gi]    <= altOe[gi];
          pinOut[gi]   <= altOut[gi];
          pullupEn[gi] <= 1'b0;
        end else begin
          pinOe[gi]    <= dirVec[gi];
          pinOut[gi]   <= dirVec[gi] & dataVec[gi];
          pullupEn[gi] <= ~dirVec[gi] & dataVec[gi]
                          & ~globalPullupDisable;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin-change masking
  // ---------------------------------------------------------------
  assign groupEn = changeGroupControl[NP-1:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      groupChange <= '0;
    end else begin
      for (int g = 0; g < NP; g++) begin
        groupChange[g] <= groupEn[g]
          & |(smp.changed[g*PW +: PW] & maskVec[g*PW +: PW]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_maskWrite0;
    regWrite && regAddr == `OFS_MASK_GROUP0;
  endsequence

  sequence s_maskWrite3;
    regWrite && regAddr == `OFS_MASK_GROUP3;
  endsequence

  sequence s_pinsWrite0;
    regWrite && regAddr == portOfs(0, `OFS_PINS_SUB);
  endsequence

  // A masked change on a pin while its group is enabled
  sequence s_hit0;
    groupEn[0] && |(smp.changed[0 +: PW] & maskVec[0 +: PW]);
  endsequence

  sequence s_hit3;
    groupEn[3] && |(smp.changed[3*PW +: PW] & maskVec[3*PW +: PW]);
  endsequence

  a_mask0_write: assert property (
    @(posedge clk) disable iff (!rstn)
    s_maskWrite0 |=> maskReg[0] == $past(regWdata))
    else $error("group0 mask not stored");
  a_mask3_write: assert property (
    @(posedge clk) disable iff (!rstn)
    s_maskWrite3 |=> maskReg[3] == $past(regWdata))
    else $error("group3 mask not stored");
  a_group_gate: assert property (
    @(posedge clk) disable iff (!rstn)
    !groupEn[1] |=> !groupChange[1])
    else $error("group1 change without enable");
  a_group2_gate: assert property (
    @(posedge clk) disable iff (!rstn)
    !groupEn[2] |=> !groupChange[2])
    else $error("group2 change without enable");
  a_mask_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    maskReg[3] == 8'h00 |=> !groupChange[3])
    else $error("change passed a cleared mask");
  a_mask_ignore: assert property (
    @(posedge clk) disable iff (!rstn)
    !(|(smp.changed[0 +: PW] & maskVec[0 +: PW])) |=> !groupChange[0])
    else $error("unmasked group0 change passed");
  a_hit0_pulse: assert property (
    @(posedge clk) disable iff (!rstn)
    s_hit0 |=> groupChange[0])
    else $error("enabled group0 change lost");
  a_hit3_pulse: assert property (
    @(posedge clk) disable iff (!rstn)
    s_hit3 |=> groupChange[3])
    else $error("enabled group3 change lost");
  a_toggle_data: assert property (
    @(posedge clk) disable iff (!rstn)
    s_pinsWrite0 |=> portOutputData[0]
      == ($past(portOutputData[0]) ^ $past(regWdata)))
    else $error("pins write did not toggle data");
  a_dir_write: assert property (
    @(posedge clk) disable iff (!rstn)
    regWrite && regAddr == portOfs(0, `OFS_DIR_SUB)
    |=> portDirection[0] == $past(regWdata))
    else $error("direction write not stored");
  a_pins_read: assert property (
    @(posedge clk) disable iff (!rstn)
    regRead && regAddr == portOfs(0, `OFS_PINS_SUB)
    |=> regRdata == $past(smp.level[0 +: PW]))
    else $error("pins read not from synchronised levels");
  a_pullup_off: assert property (
    @(posedge clk) disable iff (!rstn)
    globalPullupDisable |=> pullupEn == '0)
    else $error("pull-up on while disabled");
  a_pullup_on: assert property (
    @(posedge clk) disable iff (!rstn)
    !altEnable[0] && !dirVec[0] && dataVec[0] && !globalPullupDisable
    |=> pullupEn[0])
    else $error("input pin lost its pull-up");
  a_drive_out: assert property (
    @(posedge clk) disable iff (!rstn)
    !altEnable[0] && dirVec[0]
    |=> pinOe[0] && pinOut[0] == $past(dataVec[0]))
    else $error("output pin not driven from data");
  a_input_hiz: assert property (
    @(posedge clk) disable iff (!rstn)
    !altEnable[0] && !dirVec[0] |=> !pinOe[0])
    else $error("input pin driven");
  a_alt_override: assert property (
    @(posedge clk) disable iff (!rstn)
    altEnable[0] |=> pinOe[0] == $past(altOe[0]) && !pullupEn[0])
    else $error("alternate override not applied");
endmodule : gpio_port_pin_change_mask

// ==== tb/pin_partner.sv ====
/*
  Model of the circuitry on the 32 port pins.
  Assumes an undriven pin without pull-up follows extLevel.
*/
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOe,
  input  wire logic [31:0] pullupEn,
  input  wire logic [31:0] extLevel,
  output logic      [31:0] pinIn
);
  // Own drive wins, then the pull-up, then the outside level
  assign pinIn = (pinOe & pinOut)
               | (~pinOe & pullupEn)
               | (~pinOe & ~pullupEn & extLevel);
endmodule : pin_partner

// ==== tb/gpio_port_pin_change_mask_tb.sv ====
/*
  Self-checking bench for the port block.
  Assumes the defs header's address map.
*/
`timescale 1ns/1ps
`include "gpio_port_defs.svh"
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
  badCount++; end end
module gpio_port_pin_change_mask_tb;
  import gpio_port_pkg::*;
  logic        clk = 0, rstn = 0, regWrite = 0, regRead = 0;
  logic [7:0]  regAddr = 0, regWdata = 0, regRdata, rv;
  logic [31:0] altEnable = 0, altOut = 0, altOe = 0, extLevel = 0;
  logic [31:0] pinIn, pinOut, pinOe, pullupEn;
  logic [3:0]  groupChange;
  int          badCount = 0, nCompared = 0, cycles = 0;
  byte_t       maskOfs [4] = '{`OFS_MASK_GROUP0, `OFS_MASK_GROUP1,
                               `OFS_MASK_GROUP2, `OFS_MASK_GROUP3};
  always #10 clk = ~clk;
  gpio_port_pin_change_mask dut (.clk(clk), .rstn(rstn),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .altEnable(altEnable),
    .altOut(altOut), .altOe(altOe), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pullupEn(pullupEn), .groupChange(groupChange));
  pin_partner far (.pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .extLevel(extLevel), .pinIn(pinIn));
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a; regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // Counts high cycles of one group's change pulse over a fixed span
  task automatic pulse(input int g, input int exp);
    int cnt;
    cnt = 0;
    repeat (10) begin
      @(posedge clk);
      #1 if (groupChange[g] === 1'b1) cnt++;
    end
    `CHK("groupChange", exp, cnt)
  endtask : pulse
  task automatic flip(input int bitNo);
    @(posedge clk);
    extLevel[bitNo] <= ~extLevel[bitNo];
  endtask : flip
  task automatic testReset();
    foreach (maskOfs[g]) begin
      rd(maskOfs[g], rv);
      `CHK("mask reset", 8'h00, rv)
    end
    rd(8'h90, rv);
    `CHK("unmapped read", 8'h00, rv)
  endtask : testReset
  task automatic testChange();
    for (int g = 0; g < 4; g++) begin
      wr(`OFS_GROUP_CTRL, 8'h01 << g);
      wr(maskOfs[g], 8'h01);
      rd(maskOfs[g], rv);
      `CHK("mask rw", 8'h01, rv)
      flip(8 * g);
      pulse(g, 1);
      wr(maskOfs[g], 8'h02);
      flip(8 * g);
      pulse(g, 0);
      wr(maskOfs[g], 8'h01);
      wr(`OFS_GROUP_CTRL, 8'h00);
      flip(8 * g);
      pulse(g, 0);
      wr(maskOfs[g], 8'h00);
    end
    extLevel <= '0;
  endtask : testChange
  task automatic testPort(input int p);
    logic [7:0] b;
    b = `OFS_PORT_BASE + 8'(p) * `PORT_STRIDE;
    wr(b + `OFS_DIR_SUB, 8'ha5);
    wr(b + `OFS_DATA_SUB, 8'h3c);
    wr(b + `OFS_PINS_SUB, 8'h0f);
    wr(b + `OFS_PINS_SUB, 8'h00);
    rd(b + `OFS_DIR_SUB, rv);
    `CHK("direction", 8'ha5, rv)
    rd(b + `OFS_DATA_SUB, rv);
    `CHK("data toggled", 8'h33, rv)
    idle(4);
    `CHK("pinOe", 8'ha5, pinOe[8*p +: 8])
    `CHK("pinOut", 8'h21, pinOut[8*p +: 8] & 8'ha5)
    `CHK("pullupEn", 8'h12, pullupEn[8*p +: 8])
    rd(b + `OFS_PINS_SUB, rv);
    `CHK("pin levels", 8'h33, rv)
    wr(`OFS_MCU_CTRL, 8'h01 << `BIT_PULLUP_DIS);
    idle(2);
    `CHK("pull-up off", 32'h0, pullupEn)
    wr(`OFS_MCU_CTRL, 8'h00);
    wr(b + `OFS_DIR_SUB, 8'ha4);
    idle(2);
    `CHK("one pin input", 8'ha4, pinOe[8*p +: 8])
    `CHK("pull-up gained", 8'h13, pullupEn[8*p +: 8])
  endtask : testPort
  task automatic testAlt();
    @(posedge clk);
    altEnable[0] <= 1'b1;
    altOe[0] <= 1'b1;
    idle(3);
    `CHK("alt pin", 3'b100, {pinOe[0], pinOut[0], pullupEn[0]})
    `CHK("other pins", 7'h52, pinOe[7:1])
    `CHK("other pull-ups", 7'h09, pullupEn[7:1])
  endtask : testAlt
  task automatic printVerdict();
    $display("compared %0d mismatched %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : printVerdict
  // Run takes some hundreds of cycles; 20000 means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      printVerdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    testReset();
    testChange();
    for (int p = 0; p < 4; p++) testPort(p);
    testAlt();
    printVerdict();
  end
endmodule : gpio_port_pin_change_mask_tb
